// [core/cbt_pkg.sv]
// Purpose: shared constants and types for the bit-timing, timer and status block
// Assumes: AXI4-Lite register access, one 200 MHz clock
// Notes: offsets are byte-level indices; bus byte address is four times the index
package cbt_pkg;
  localparam int CBT_CLK_MHZ = 200;
  localparam logic [7:0] CBT_IDX_BAUD = 8'hE2;
  localparam logic [7:0] CBT_IDX_SYNC_PROP = 8'hE3;
  localparam logic [7:0] CBT_IDX_PHASE_SAMPLE = 8'hE4;
  localparam logic [7:0] CBT_IDX_TMR_PRESCALE = 8'hE5;
  localparam logic [7:0] CBT_IDX_TMR_COUNT = 8'hE6;
  localparam logic [7:0] CBT_IDX_TTC = 8'hE8;
  localparam logic [7:0] CBT_IDX_TEC = 8'hEA;
  localparam logic [7:0] CBT_IDX_REC = 8'hEB;
  localparam logic [7:0] CBT_IDX_TOP_SLOT = 8'hEC;
  localparam logic [7:0] CBT_IDX_CTRL = 8'hF8;
  localparam logic [7:0] CBT_IDX_FLAGS = 8'hF9;
  localparam int CBT_ADDR_W = 10;
  localparam logic [7:0] CBT_RST_BYTE = 8'h00;
  localparam logic [3:0] CBT_NO_SLOT = 4'hF;
  localparam int CBT_TMR_DIV = 8;
  localparam int CBT_SJW_LSB = 5;
  localparam int CBT_PRS_LSB = 1;
  localparam int CBT_PHASE_SEG_TWO_LSB = 4;
  localparam int CBT_PHASE_SEG_ONE_LSB = 1;
  localparam int CBT_SMP_BIT = 0;
  localparam logic [1:0] CBT_RESP_OKAY = 2'b00;
  localparam logic [1:0] CBT_RESP_SLVERR = 2'b10;
  localparam logic [8:0] CBT_BUS_OFF = 9'h100;
  localparam logic [7:0] CBT_PASSIVE = 8'h80;

  typedef enum logic [1:0] {
    CBT_SYNC = 2'b00,
    CBT_PROP = 2'b01,
    CBT_PH1 = 2'b11,
    CBT_PH2 = 2'b10
  } cbt_seg_t;

  typedef struct packed {
    logic awvalid;
    logic [CBT_ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [CBT_ADDR_W-1:0] araddr;
    logic rready;
  } cbt_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cbt_axi_rsp_t;

  // fault-confinement events from the frame engine, one-cycle pulses
  typedef struct packed {
    logic txErr;
    logic txErrDominant;
    logic txOk;
    logic rxErr;
    logic rxErrPrimary;
    logic rxOk;
  } cbt_fault_ev_t;
endpackage : cbt_pkg

// [core/cbt_core.sv]
// Purpose: bit timing, bus timer, fault counters and top slot readback of a CAN controller
// Assumes: AXI4-Lite slave, synchronous active-high reset, all inputs synchronous to clk
// Notes: register space indexed by byte offset, one 32-bit word per index
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module cbt_core
  import cbt_pkg::*;
#(
  parameter int SLOTS = 6
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire cbt_pkg::cbt_axi_req_t axiReq,
  output cbt_pkg::cbt_axi_rsp_t axiRsp,
  input wire logic busRx,
  input wire logic ctrlEnable,
  input wire logic ttcCapture,
  input wire cbt_pkg::cbt_fault_ev_t faultEv,
  input wire logic [SLOTS-1:0] slotIntStatus,
  output logic quantumTick,
  output logic samplePulse,
  output logic sampledBit,
  output logic bitStart,
  output logic timerWrapFlag,
  output logic [15:0] busTimerValue,
  output logic errorPassive,
  output logic busOff
);
  import cbt_pkg::*;

  // fifteen is the empty code, so at most fifteen slots can be named
  if (SLOTS < 1 || SLOTS > 15)
  begin : g_slots_bad
    $error("SLOTS must be 1 to 15");
  end

  typedef struct packed {
    logic [7:0] baud;
    logic [7:0] syncProp;
    logic [7:0] phaseSample;
    logic [7:0] tmrPrescale;
    logic [3:0] genBits;
    logic wrapFlag;
    logic [15:0] tmr;
    logic [15:0] ttc;
    logic [10:0] tmrDiv;
    logic [5:0] tqCnt;
    cbt_seg_t seg;
    logic [3:0] segCnt;
    logic [3:0] segLen;
    logic busPrev;
    logic [1:0] hist;
    logic sampleBit;
    logic resyncDone;
    logic [8:0] transmit_fault_counter;
    logic [7:0] receive_fault_counter;
    logic awHeld;
    logic [CBT_ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } cbt_state_t;

  cbt_state_t state_r;
  cbt_state_t state_nxt;

  logic [5:0] baudPre;
  logic [2:0] sjwQ;
  logic [2:0] prsQ;
  logic [2:0] ph1Q;
  logic [2:0] ph2Q;
  logic smpMode;
  logic tqEnd;
  logic segEnd;
  logic fallEdge;
  logic [3:0] topSlot;
  logic [7:0] rdIdx;
  logic [7:0] wrIdx;
  logic [31:0] rdWord;
  logic rdHit;
  logic wrHit;
  logic majority;
  logic [10:0] tmrDivLast;

  assign baudPre = state_r.baud[6:1];
  assign sjwQ = {1'b0, state_r.syncProp[CBT_SJW_LSB +: 2]};
  assign prsQ = state_r.syncProp[CBT_PRS_LSB +: 3];
  assign ph2Q = state_r.phaseSample[CBT_PHASE_SEG_TWO_LSB +: 3];
  assign ph1Q = state_r.phaseSample[CBT_PHASE_SEG_ONE_LSB +: 3];
  assign smpMode = state_r.phaseSample[CBT_SMP_BIT];
  assign tqEnd = clkEn && (state_r.tqCnt == baudPre);
  assign segEnd = tqEnd && (state_r.segCnt >= state_r.segLen);
  // only recessive-to-dominant edges resync, once per bit
  assign fallEdge = state_r.busPrev && !busRx && !state_r.resyncDone;
  assign majority = (state_r.hist[1] & state_r.hist[0]) | (state_r.hist[1] & busRx) |
    (state_r.hist[0] & busRx);
  assign tmrDivLast = 11'(CBT_TMR_DIV) * ({3'b000, state_r.tmrPrescale} + 11'h001) - 11'h001;

  always_comb
  begin
    topSlot = CBT_NO_SLOT;
    for (int i = SLOTS - 1; i >= 0; i--)
    begin
      if (slotIntStatus[i])
        topSlot = 4'(i);
    end
  end

  assign rdIdx = axiReq.araddr[CBT_ADDR_W-1:2];
  assign wrIdx = state_r.awAddr[CBT_ADDR_W-1:2];

  always_comb
  begin
    rdHit = 1'b1;
    rdWord = 32'h0000_0000;
    case (rdIdx)
      CBT_IDX_BAUD: rdWord[7:0] = state_r.baud;
      CBT_IDX_SYNC_PROP: rdWord[7:0] = state_r.syncProp;
      CBT_IDX_PHASE_SAMPLE: rdWord[7:0] = state_r.phaseSample;
      CBT_IDX_TMR_PRESCALE: rdWord[7:0] = state_r.tmrPrescale;
      CBT_IDX_TMR_COUNT: rdWord[15:0] = state_r.tmr;
      CBT_IDX_TTC: rdWord[15:0] = state_r.ttc;
      CBT_IDX_TEC: rdWord[7:0] = state_r.transmit_fault_counter[8] ? 8'hFF : state_r.transmit_fault_counter[7:0];
      CBT_IDX_REC: rdWord[7:0] = state_r.receive_fault_counter;
      CBT_IDX_TOP_SLOT: rdWord[7:0] = {topSlot, state_r.genBits};
      CBT_IDX_FLAGS: rdWord[2:0] = {busOff, errorPassive, state_r.wrapFlag};
      default: rdHit = 1'b0;
    endcase
  end

  always_comb
  begin
    wrHit = 1'b1;
    case (wrIdx)
      CBT_IDX_BAUD, CBT_IDX_SYNC_PROP, CBT_IDX_PHASE_SAMPLE, CBT_IDX_TMR_PRESCALE,
      CBT_IDX_TOP_SLOT, CBT_IDX_FLAGS, CBT_IDX_TMR_COUNT, CBT_IDX_TTC, CBT_IDX_TEC,
      CBT_IDX_REC: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;
    if (clkEn)
    begin
      // bus slave
      if (axiReq.awvalid && !state_r.awHeld)
      begin
        state_nxt.awHeld = 1'b1;
        state_nxt.awAddr = axiReq.awaddr;
      end
      if (axiReq.wvalid && !state_r.wHeld)
      begin
        state_nxt.wHeld = 1'b1;
        state_nxt.wData = axiReq.wdata;
        state_nxt.wStrb = axiReq.wstrb;
      end
      if (state_r.awHeld && state_r.wHeld && !state_r.bValid)
      begin
        state_nxt.awHeld = 1'b0;
        state_nxt.wHeld = 1'b0;
        state_nxt.bValid = 1'b1;
        state_nxt.bResp = wrHit ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
        if (state_r.wStrb[0])
        begin
          case (wrIdx)
            CBT_IDX_BAUD: state_nxt.baud = state_r.wData[7:0];
            CBT_IDX_SYNC_PROP: state_nxt.syncProp = state_r.wData[7:0];
            CBT_IDX_PHASE_SAMPLE: state_nxt.phaseSample = state_r.wData[7:0];
            CBT_IDX_TMR_PRESCALE: state_nxt.tmrPrescale = state_r.wData[7:0];
            CBT_IDX_TOP_SLOT: state_nxt.genBits = state_r.wData[3:0];
            default: state_nxt.genBits = state_nxt.genBits;
          endcase
        end
      end
      if (state_r.bValid && axiReq.bready)
        state_nxt.bValid = 1'b0;
      if (axiReq.arvalid && !state_r.rValid)
      begin
        state_nxt.rValid = 1'b1;
        state_nxt.rData = rdWord;
        state_nxt.rResp = rdHit ? CBT_RESP_OKAY : CBT_RESP_SLVERR;
      end
      if (state_r.rValid && axiReq.rready)
        state_nxt.rValid = 1'b0;

      // time base and capture
      if (ctrlEnable)
      begin
        if (state_r.tmrDiv >= tmrDivLast)
        begin
          state_nxt.tmrDiv = 11'h000;
          state_nxt.tmr = state_r.tmr + 16'h0001;
          if (state_r.tmr == 16'hFFFF)
            state_nxt.wrapFlag = 1'b1;
        end
        else
          state_nxt.tmrDiv = state_r.tmrDiv + 11'h001;
      end
      if (ttcCapture)
        state_nxt.ttc = state_r.tmr;
      // write-one clears; a wrap in the same cycle wins
      if (state_r.awHeld && state_r.wHeld && !state_r.bValid && wrIdx == CBT_IDX_FLAGS &&
          state_r.wStrb[0] && state_r.wData[0] &&
          !(ctrlEnable && state_r.tmrDiv >= tmrDivLast && state_r.tmr == 16'hFFFF))
        state_nxt.wrapFlag = 1'b0;

      // bit timing
      state_nxt.busPrev = busRx;
      state_nxt.hist = {state_r.hist[0], busRx};
      state_nxt.tqCnt = tqEnd ? 6'h00 : state_r.tqCnt + 6'h01;
      if (tqEnd)
        state_nxt.segCnt = state_r.segCnt + 4'h1;
      if (segEnd)
      begin
        state_nxt.segCnt = 4'h0;
        case (state_r.seg)
          CBT_SYNC:
          begin
            state_nxt.seg = CBT_PROP;
            state_nxt.segLen = {1'b0, prsQ};
          end
          CBT_PROP:
          begin
            state_nxt.seg = CBT_PH1;
            state_nxt.segLen = {1'b0, ph1Q};
          end
          CBT_PH1:
          begin
            state_nxt.seg = CBT_PH2;
            state_nxt.segLen = {1'b0, ph2Q};
            state_nxt.sampleBit = smpMode ? majority : busRx;
          end
          CBT_PH2:
          begin
            state_nxt.seg = CBT_SYNC;
            state_nxt.segLen = 4'h0;
            state_nxt.resyncDone = 1'b0;
          end
          default:
          begin
            state_nxt.seg = CBT_SYNC;
            state_nxt.segLen = 4'h0;
          end
        endcase
      end
      if (fallEdge && state_r.seg != CBT_SYNC)
      begin
        state_nxt.resyncDone = 1'b1;
        if (state_r.seg == CBT_PH2)
        begin
          // edge late in phase two: shorten by up to the jump width
          state_nxt.seg = CBT_SYNC;
          state_nxt.segLen = 4'h0;
          state_nxt.segCnt = 4'h0;
          state_nxt.tqCnt = 6'h00;
          state_nxt.resyncDone = 1'b0;
          if ({1'b0, ph2Q} - state_r.segCnt > {1'b0, sjwQ})
          begin
            state_nxt.seg = CBT_PH2;
            state_nxt.segLen = {1'b0, ph2Q} - {1'b0, sjwQ} - 4'h1;
            state_nxt.segCnt = state_r.segCnt;
            state_nxt.tqCnt = state_r.tqCnt;
            state_nxt.resyncDone = 1'b1;
          end
        end
        else if (!segEnd || state_r.seg == CBT_PROP)
        begin
          // late edge: push the sample point back by the full jump width, not capped by
          // the phase error; stretching propagation moves it just as phase one would
          state_nxt.segLen = state_nxt.segLen + {1'b0, sjwQ} + 4'h1;
        end
      end

      // fault confinement
      if (faultEv.txErr)
        state_nxt.transmit_fault_counter = (state_r.transmit_fault_counter > 9'h1F7) ? CBT_BUS_OFF : state_r.transmit_fault_counter + 9'h008;
      else if (faultEv.txOk && state_r.transmit_fault_counter != 9'h000 && !state_r.transmit_fault_counter[8])
        state_nxt.transmit_fault_counter = state_r.transmit_fault_counter - 9'h001;
      if (faultEv.rxErrPrimary)
        state_nxt.receive_fault_counter = (state_r.receive_fault_counter > 8'hF7) ? 8'hFF : state_r.receive_fault_counter + 8'h08;
      else if (faultEv.rxErr)
        state_nxt.receive_fault_counter = (state_r.receive_fault_counter == 8'hFF) ? 8'hFF : state_r.receive_fault_counter + 8'h01;
      else if (faultEv.rxOk)
        state_nxt.receive_fault_counter = (state_r.receive_fault_counter > CBT_PASSIVE) ? 8'h7F :
          (state_r.receive_fault_counter == 8'h00 ? 8'h00 : state_r.receive_fault_counter - 8'h01);
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= '0;
      state_r.seg <= CBT_SYNC;
    end
    else
      state_r <= state_nxt;
  end

  assign axiRsp.awready = clkEn && !state_r.awHeld;
  assign axiRsp.wready = clkEn && !state_r.wHeld;
  assign axiRsp.bvalid = state_r.bValid;
  assign axiRsp.bresp = state_r.bResp;
  assign axiRsp.arready = clkEn && !state_r.rValid;
  assign axiRsp.rvalid = state_r.rValid;
  assign axiRsp.rdata = state_r.rData;
  assign axiRsp.rresp = state_r.rResp;
  assign quantumTick = tqEnd;
  assign samplePulse = segEnd && state_r.seg == CBT_PH1;
  assign sampledBit = state_r.sampleBit;
  assign bitStart = segEnd && state_r.seg == CBT_PH2;
  assign timerWrapFlag = state_r.wrapFlag;
  assign busTimerValue = state_r.tmr;
  assign errorPassive = state_r.transmit_fault_counter > 9'h07F || state_r.receive_fault_counter > 8'h7F;
  assign busOff = state_r.transmit_fault_counter[8];

  // assertions
  wrap_sets_flag_a: assert property (@(posedge clk) disable iff (srst)
    clkEn && ctrlEnable && state_r.tmrDiv >= tmrDivLast && state_r.tmr == 16'hFFFF
    |=> state_r.wrapFlag && state_r.tmr == 16'h0000)
    else $error("timer wrap did not set flag");
  timer_frozen_a: assert property (@(posedge clk) disable iff (srst)
    !ctrlEnable |=> $stable(state_r.tmr))
    else $error("timer moved while controller disabled");
  timer_step_a: assert property (@(posedge clk) disable iff (srst)
    !$stable(state_r.tmr) |-> state_r.tmr == $past(state_r.tmr) + 16'h0001)
    else $error("timer did not count up by one");
  no_slot_a: assert property (@(posedge clk) disable iff (srst)
    slotIntStatus == '0 |-> topSlot == CBT_NO_SLOT)
    else $error("empty status must give fifteen");
  top_slot_a: assert property (@(posedge clk) disable iff (srst)
    slotIntStatus[0] |-> topSlot == 4'h0)
    else $error("slot zero must win");
  quantum_len_a: assert property (@(posedge clk) disable iff (srst)
    tqEnd && clkEn ##1 clkEn [*1] |-> !tqEnd || baudPre == 6'h00)
    else $error("quantum ended too early");
  single_sample_a: assert property (@(posedge clk) disable iff (srst)
    samplePulse && !smpMode |=> state_r.sampleBit == $past(busRx))
    else $error("single sample mismatch");
  sequence sampleSeq;
    samplePulse && smpMode;
  endsequence
  triple_sample_a: assert property (@(posedge clk) disable iff (srst)
    sampleSeq |=> state_r.sampleBit == $past(majority))
    else $error("majority sample mismatch");
  tec_step_a: assert property (@(posedge clk) disable iff (srst)
    clkEn && faultEv.txErr && state_r.transmit_fault_counter < 9'h0F0
    |=> state_r.transmit_fault_counter == $past(state_r.transmit_fault_counter) + 9'h008)
    else $error("transmit fault step wrong");
  gen_bits_a: assert property (@(posedge clk) disable iff (srst)
    !(clkEn && state_r.awHeld && state_r.wHeld) |=> $stable(state_r.genBits))
    else $error("general bits changed without write");
endmodule : cbt_core
`default_nettype wire

// [bench/cbt_bus_node.sv]
// Purpose: far-side node that drives the received bus level
// Assumes: a 16-clock bit while a spike is requested
// Notes: the one-clock inverted spike lands on the next sample point
`timescale 1ns/10ps
`default_nettype none
module cbt_bus_node
(
  input wire logic clk,
  input wire logic srst,
  input wire logic samplePulse,
  input wire logic dominant,
  input wire logic glitchReq,
  output logic busRx,
  output logic glitchDone
);
  logic [4:0] cnt;
  // recessive idle level is high on a real bus, so no stale value is left
  always @(posedge clk)
  begin
    if (srst)
    begin
      cnt <= 5'h00;
      busRx <= 1'b1;
      glitchDone <= 1'b0;
    end
    else
    begin
      busRx <= !dominant ^ (cnt == 5'h0F);
      glitchDone <= glitchReq && (glitchDone || cnt == 5'h10);
      if (cnt == 5'h10)
        cnt <= 5'h00;
      else if (cnt != 5'h00 || (glitchReq && samplePulse && !glitchDone))
        cnt <= cnt + 5'h01;
    end
  end
endmodule : cbt_bus_node
`default_nettype wire

// [bench/test_can_bit_timing_timer_status.sv]
// Purpose: self-checking bench for the bit timing, timer and status block
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: timer wrap is left to the design's own assertions; it takes too long
`timescale 1ns/10ps
`default_nettype none
module test_can_bit_timing_timer_status;
  import cbt_pkg::*;
  logic clk, srst, clkEn, busRx, ctrlEnable, ttcCapture, dominant, glitchReq, glitchDone;
  logic quantumTick, samplePulse, sampledBit, bitStart, timerWrapFlag, errorPassive, busOff;
  logic [15:0] busTimerValue;
  logic [15:0] v;
  logic [5:0] slotIntStatus;
  cbt_axi_req_t req;
  cbt_axi_rsp_t rsp;
  cbt_fault_ev_t ev;
  logic [31:0] rd;
  logic [1:0] rr;
  int n_fail, num_checks, t;

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  cbt_core cbt_core_i (.clk(clk), .srst(srst), .clkEn(clkEn), .axiReq(req), .axiRsp(rsp),
    .busRx(busRx), .ctrlEnable(ctrlEnable), .ttcCapture(ttcCapture), .faultEv(ev),
    .slotIntStatus(slotIntStatus), .quantumTick(quantumTick), .samplePulse(samplePulse),
    .sampledBit(sampledBit), .bitStart(bitStart), .timerWrapFlag(timerWrapFlag),
    .busTimerValue(busTimerValue), .errorPassive(errorPassive), .busOff(busOff));

  cbt_bus_node cbt_bus_node_i (.clk(clk), .srst(srst), .samplePulse(samplePulse),
    .dominant(dominant), .glitchReq(glitchReq), .busRx(busRx), .glitchDone(glitchDone));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic axw(input logic [7:0] idx, input logic [7:0] d);
    logic awd, wd;
    awd = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(awd && wd))
    begin
      @(posedge clk);
      if (rsp.awready && !awd)
      begin
        awd = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready && !wd)
      begin
        wd = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!rsp.bvalid);
    req.bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] idx);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    req.rready <= 1'b1;
    do @(posedge clk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (!rsp.rvalid);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask : axr

  task automatic pulse(input logic [5:0] e, input int n);
    repeat (n)
    begin
      @(posedge clk);
      ev <= cbt_fault_ev_t'(e);
      @(posedge clk);
      ev <= '0;
    end
    // let the last event land before anyone looks at the counters
    @(posedge clk);
  endtask : pulse

  // counts edges until the flag is seen, bounded so a dead design cannot hang here
  task automatic gap(input int sel);
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (!(sel == 0 ? bitStart : sel == 1 ? samplePulse : sel == 3 ? quantumTick :
      busTimerValue !== v) && t < 200);
  endtask : gap

  task automatic t_reset;
    logic [7:0] idx [8] = '{CBT_IDX_BAUD, CBT_IDX_SYNC_PROP, CBT_IDX_PHASE_SAMPLE,
      CBT_IDX_TMR_PRESCALE, CBT_IDX_TMR_COUNT, CBT_IDX_TTC, CBT_IDX_TEC, CBT_IDX_REC};
    foreach (idx[i])
    begin
      axr(idx[i]);
      check("reset value", rd, 32'h0);
      check("read response", {30'h0, rr}, {30'h0, CBT_RESP_OKAY});
    end
    axr(CBT_IDX_TOP_SLOT);
    check("empty top slot", rd, 32'hF0);
    axr(8'h80);
    check("unmapped response", {30'h0, rr}, {30'h0, CBT_RESP_SLVERR});
  endtask : t_reset

  task automatic t_regs;
    axw(CBT_IDX_SYNC_PROP, 8'h6E);
    axw(CBT_IDX_PHASE_SAMPLE, 8'h7E);
    axw(CBT_IDX_TMR_PRESCALE, 8'hA5);
    axw(CBT_IDX_TMR_COUNT, 8'h55);
    axr(CBT_IDX_SYNC_PROP);
    check("sync prop", rd, 32'h6E);
    axr(CBT_IDX_PHASE_SAMPLE);
    check("phase sample", rd, 32'h7E);
    axr(CBT_IDX_TMR_PRESCALE);
    check("timer prescale", rd, 32'hA5);
    axr(CBT_IDX_TMR_COUNT);
    check("timer read only", rd, 32'h0);
  endtask : t_regs

  task automatic t_slot;
    slotIntStatus <= 6'b101100;
    axw(CBT_IDX_TOP_SLOT, 8'hFA);
    axr(CBT_IDX_TOP_SLOT);
    check("top slot", rd, 32'h2A);
    slotIntStatus <= 6'b100000;
    axr(CBT_IDX_TOP_SLOT);
    check("top slot last", rd, 32'h5A);
  endtask : t_slot

  task automatic t_timer;
    axw(CBT_IDX_TMR_PRESCALE, 8'h02);
    ctrlEnable <= 1'b1;
    v = busTimerValue;
    gap(2);
    v = busTimerValue;
    gap(2);
    check("timer period", t, 24);
    ctrlEnable <= 1'b0;
    repeat (2) @(posedge clk);
    v = busTimerValue;
    repeat (60) @(posedge clk);
    check("timer frozen", busTimerValue, v);
    axr(CBT_IDX_TMR_COUNT);
    check("timer read", rd, {16'h0, v});
    ttcCapture <= 1'b1;
    @(posedge clk);
    ttcCapture <= 1'b0;
    axr(CBT_IDX_TTC);
    check("capture", rd, {16'h0, v});
  endtask : t_timer

  task automatic spike(input logic exp);
    repeat (64) @(posedge clk);
    check("steady sample", sampledBit, 1'b0);
    glitchReq <= 1'b1;
    t = 0;
    while (!glitchDone && t < 200)
    begin
      @(posedge clk);
      t++;
    end
    check("spike done", glitchDone, 1'b1);
    glitchReq <= 1'b0;
    repeat (2) @(posedge clk);
    check("spike sample", sampledBit, exp);
  endtask : spike

  task automatic t_bits;
    // quantum of two clocks; bit of 1+2+3+2 quanta; prescaler is not zero for triple mode
    axw(CBT_IDX_BAUD, 8'h02);
    axw(CBT_IDX_SYNC_PROP, 8'h02);
    axw(CBT_IDX_PHASE_SAMPLE, 8'h14);
    gap(0);
    gap(0);
    check("bit length", t, 16);
    gap(1);
    gap(0);
    check("phase two length", t, 4);
    gap(3);
    gap(3);
    check("quantum length", t, 2);
    dominant <= 1'b1;
    spike(1'b1);
    axw(CBT_IDX_PHASE_SAMPLE, 8'h15);
    spike(1'b0);
  endtask : t_bits

  task automatic t_fault;
    pulse(6'b100000, 2);
    pulse(6'b001000, 1);
    pulse(6'b000100, 2);
    pulse(6'b000001, 1);
    axr(CBT_IDX_TEC);
    check("tx count", rd, 32'h0F);
    axr(CBT_IDX_REC);
    check("rx count", rd, 32'h01);
    pulse(6'b100000, 14);
    check("not passive", errorPassive, 1'b0);
    pulse(6'b100000, 1);
    axr(CBT_IDX_FLAGS);
    check("passive flag", rd[2:1], 2'b01);
    check("wrap flag idle", {rd[0], timerWrapFlag}, 2'b00);
    pulse(6'b100000, 16);
    check("bus off", busOff, 1'b1);
    axr(CBT_IDX_TEC);
    check("tx count off", rd, 32'hFF);
  endtask : t_fault

  task automatic final_report;
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    srst = 1'b1;
    clkEn = 1'b1;
    ctrlEnable = 1'b0;
    ttcCapture = 1'b0;
    dominant = 1'b0;
    glitchReq = 1'b0;
    slotIntStatus = 6'h00;
    req = '0;
    ev = '0;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_regs();
    t_slot();
    t_timer();
    t_bits();
    t_fault();
    final_report();
  end

  // a run needs under a thousand cycles; forty thousand means a hang
  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule : test_can_bit_timing_timer_status
`default_nettype wire
